// [shared/mpd_pkg.sv]
// constants and types for the pin readback and microphone control block
package mpd_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_PINS  = 14;
  localparam int NUM_BCLK  = 8;
  localparam int NUM_PAIRS = 2;
  localparam int NUM_MICS  = 4;
  localparam int SYNC_W    = NUM_PINS + NUM_BCLK;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [15:0]             mpd_word_t;
  typedef logic [15:0]             mpd_addr_t;
  typedef logic [NUM_PINS-1:0]     mpd_pin_vec_t;
  typedef logic [2:0]              mpd_mode_t;
  typedef mpd_mode_t [NUM_PINS-1:0] mpd_mode_vec_t;
  typedef logic [NUM_BCLK-1:0]     mpd_bclk_vec_t;
  typedef logic [NUM_MICS-1:0]     mpd_mic_vec_t;
  typedef logic [NUM_PAIRS-1:0]    mpd_pair_vec_t;
  typedef logic [2:0]              mpd_cutoff_t;
  typedef mpd_cutoff_t [NUM_PAIRS-1:0] mpd_cutoff_vec_t;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam mpd_addr_t READBACK_BASE  = 16'hF530;
  localparam mpd_addr_t READBACK_LAST  = 16'hF53D;
  localparam mpd_addr_t MIC_CTRL0_ADDR = 16'hF560;
  localparam mpd_addr_t MIC_CTRL1_ADDR = 16'hF561;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam mpd_word_t READBACK_RESET = 16'h0000;
  localparam mpd_word_t MIC_CTRL_RESET = 16'h4000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PIN_LEVEL_BIT  = 0;
  localparam int HPF_ENABLE_BIT = 3;
  localparam int CLK_SEL_LSB    = 4;
  localparam int CLK_SEL_MSB    = 6;
  localparam int PIN_SEL_LSB    = 8;
  localparam int PIN_SEL_MSB    = 11;
  localparam int CUTOFF_LSB     = 12;
  localparam int CUTOFF_MSB     = 14;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam mpd_mode_t   MODE_GP_IN      = 3'h0;
  localparam mpd_mode_t   MODE_GP_IN_PORT = 3'h1;
  localparam mpd_mode_t   MODE_MIC_IN     = 3'h4;
  localparam logic [3:0]  PIN_SEL_MAX     = 4'hD;
  localparam mpd_cutoff_t CUTOFF_OFF      = 3'h0;

endpackage

// [shared/mpd_sync_if.sv]
// carrier between the synchroniser bank and the register block
`timescale 1ns/100ps
interface mpd_sync_if;
  logic [mpd_pkg::SYNC_W-1:0] raw;
  logic [mpd_pkg::SYNC_W-1:0] sync;

  modport drv (input raw, output sync);
  modport use_side (output raw, input sync);
endinterface

// [verilog/mpd_sync.sv]
// two-stage synchroniser bank for pin levels and bit clocks
`timescale 1ns/100ps
module mpd_sync (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  // raw in, settled out
  mpd_sync_if.drv     bus
);
  import mpd_pkg::*;

  logic [SYNC_W-1:0] stage1_q;
  logic [SYNC_W-1:0] stage2_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= bus.raw;
      stage2_q <= stage1_q;
    end
  end

  assign bus.sync = stage2_q;

endmodule

// [verilog/mpd_top.sv]
// pin level readback registers and microphone pair control registers
`timescale 1ns/100ps
module mpd_top (
  // clock and reset
  input  wire logic                    I_CLK,
  input  wire logic                    I_RESET,
  // control port
  input  wire mpd_pkg::mpd_addr_t      I_ADDR,
  input  wire logic                    I_WR_EN,
  input  wire mpd_pkg::mpd_word_t      I_WR_DATA,
  input  wire logic                    I_RD_EN,
  output mpd_pkg::mpd_word_t           O_RD_DATA,
  output logic                         O_RD_VALID,
  // pin configuration held elsewhere
  input  wire mpd_pkg::mpd_pin_vec_t   I_PIN_MULTIPURPOSE_ENABLE,
  input  wire mpd_pkg::mpd_mode_vec_t  I_PIN_FUNCTION_MODE,
  // pins and bit clocks
  input  wire mpd_pkg::mpd_pin_vec_t   I_PIN,
  input  wire mpd_pkg::mpd_bclk_vec_t  I_BIT_CLOCK,
  // microphone data out
  output mpd_pkg::mpd_mic_vec_t        O_MIC_DATA,
  output mpd_pkg::mpd_mic_vec_t        O_MIC_VALID,
  // high-pass settings out
  output mpd_pkg::mpd_pair_vec_t       O_HPF_ENABLE,
  output mpd_pkg::mpd_cutoff_vec_t     O_HPF_CUTOFF
);
  import mpd_pkg::*;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  mpd_sync_if sync_bus ();

  assign sync_bus.raw = {I_BIT_CLOCK, I_PIN};

  mpd_sync u_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .bus     (sync_bus.drv)
  );

  wire logic [NUM_PINS-1:0] pin_sync  = sync_bus.sync[NUM_PINS-1:0];
  wire logic [NUM_BCLK-1:0] bclk_sync = sync_bus.sync[SYNC_W-1:NUM_PINS];

  // ****************************************************************
  // pin level readback
  // ****************************************************************
  logic [NUM_PINS-1:0] in_mask;
  logic [NUM_PINS-1:0] readback_d;
  logic [NUM_PINS-1:0] readback_q;
  logic [NUM_PINS-1:0] mic_mode;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    wire mpd_mode_t mode = I_PIN_FUNCTION_MODE[g];
    wire logic      is_in = (mode == MODE_GP_IN) || (mode == MODE_GP_IN_PORT) ||
                            (mode == MODE_MIC_IN);
    // disabled pins keep their primary function and read back low
    assign in_mask[g]  = I_PIN_MULTIPURPOSE_ENABLE[g] && is_in;
    assign mic_mode[g] = I_PIN_MULTIPURPOSE_ENABLE[g] && (mode == MODE_MIC_IN);
  end

  assign readback_d = pin_sync & in_mask;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      readback_q <= READBACK_RESET[NUM_PINS-1:0];
    end else begin
      readback_q <= readback_d;
    end
  end

  // ****************************************************************
  // microphone control registers
  // ****************************************************************
  localparam mpd_addr_t CTRL_ADDR [NUM_PAIRS] = '{MIC_CTRL0_ADDR, MIC_CTRL1_ADDR};

  mpd_word_t [NUM_PAIRS-1:0] ctrl_q;
  logic      [NUM_PAIRS-1:0] ctrl_hit;

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_ctrl
    assign ctrl_hit[p] = (I_ADDR == CTRL_ADDR[p]);

    always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
        ctrl_q[p] <= MIC_CTRL_RESET;
      end else if (I_WR_EN && ctrl_hit[p]) begin
        ctrl_q[p] <= I_WR_DATA;
      end
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  wire logic       rb_hit   = (I_ADDR >= READBACK_BASE) && (I_ADDR <= READBACK_LAST);
  wire logic [3:0] rb_index = 4'(I_ADDR - READBACK_BASE);
  wire logic       rb_level = rb_hit ? readback_q[rb_index] : 1'b0;
  wire mpd_word_t  rd_word  = rb_hit      ? {15'h0000, rb_level} :
                              ctrl_hit[0] ? ctrl_q[0] :
                              ctrl_hit[1] ? ctrl_q[1] :
                              16'h0000;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_RD_DATA  <= 16'h0000;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_EN;
      if (I_RD_EN) begin
        O_RD_DATA <= rd_word;
      end
    end
  end

  // ****************************************************************
  // microphone pairs
  // ****************************************************************
  logic [NUM_PAIRS-1:0] sel_data;
  logic [NUM_PAIRS-1:0] src_ok;
  logic [NUM_PAIRS-1:0] bclk_sel;
  logic [NUM_PAIRS-1:0] bclk_prev_q;
  logic [NUM_PAIRS-1:0] bclk_rise;
  logic [NUM_PAIRS-1:0] bclk_fall;

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    wire logic [3:0] pin_code = ctrl_q[p][PIN_SEL_MSB:PIN_SEL_LSB];
    wire logic [2:0] clk_code = ctrl_q[p][CLK_SEL_MSB:CLK_SEL_LSB];
    wire logic       code_ok  = (pin_code <= PIN_SEL_MAX);

    assign sel_data[p]  = code_ok ? pin_sync[pin_code] : 1'b0;
    assign src_ok[p]    = code_ok ? mic_mode[pin_code] : 1'b0;
    assign bclk_sel[p]  = bclk_sync[clk_code];
    assign bclk_rise[p] = bclk_sel[p] && !bclk_prev_q[p];
    assign bclk_fall[p] = !bclk_sel[p] && bclk_prev_q[p];

    always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
        bclk_prev_q[p]    <= 1'b0;
        O_MIC_DATA[2*p]   <= 1'b0;
        O_MIC_DATA[2*p+1] <= 1'b0;
        O_MIC_VALID[2*p]   <= 1'b0;
        O_MIC_VALID[2*p+1] <= 1'b0;
        O_HPF_ENABLE[p]   <= 1'b0;
        O_HPF_CUTOFF[p]   <= CUTOFF_OFF;
      end else begin
        bclk_prev_q[p] <= bclk_sel[p];
        // even channel on rising edge, odd channel on falling edge
        O_MIC_VALID[2*p]   <= bclk_rise[p] && src_ok[p];
        O_MIC_VALID[2*p+1] <= bclk_fall[p] && src_ok[p];
        if (bclk_rise[p]) begin
          O_MIC_DATA[2*p] <= sel_data[p];
        end
        if (bclk_fall[p]) begin
          O_MIC_DATA[2*p+1] <= sel_data[p];
        end
        O_HPF_ENABLE[p] <= ctrl_q[p][HPF_ENABLE_BIT];
        O_HPF_CUTOFF[p] <= ctrl_q[p][HPF_ENABLE_BIT] ?
                           ctrl_q[p][CUTOFF_MSB:CUTOFF_LSB] : CUTOFF_OFF;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  property p_readback_tracks_pin;
    (!$past(I_RESET) && !$past(I_RESET, 2) && !$past(I_RESET, 3) && $past(in_mask[0]))
      |-> (readback_q[0] == $past(I_PIN[0], 3));
  endproperty
  a_readback_tracks_pin: assert property (p_readback_tracks_pin)
    else $error("readback bit does not follow pin level");

  property p_readback_upper_zero;
    (O_RD_VALID && $past(rb_hit)) |-> (O_RD_DATA[15:1] == 15'h0000);
  endproperty
  a_readback_upper_zero: assert property (p_readback_upper_zero)
    else $error("readback upper bits not zero");

  property p_readback_disabled;
    !$past(I_PIN_MULTIPURPOSE_ENABLE[5]) && !$past(I_RESET) |-> !readback_q[5];
  endproperty
  a_readback_disabled: assert property (p_readback_disabled)
    else $error("readback set on pin without multipurpose enable");

  property p_ctrl_write;
    ($past(I_WR_EN) && $past(I_ADDR) == MIC_CTRL1_ADDR && !$past(I_RESET))
      |-> (ctrl_q[1] == $past(I_WR_DATA)) ##1 (!$past(I_WR_EN) || ctrl_q[1] == $past(ctrl_q[1])
      || $past(I_ADDR) == MIC_CTRL1_ADDR);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("second control register did not take write");

  property p_ctrl_reset;
    $past(I_RESET) |-> (ctrl_q[0] == MIC_CTRL_RESET) && (ctrl_q[1] == MIC_CTRL_RESET);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("control register reset value wrong");

  property p_hpf_gate;
    !$past(I_RESET) |-> (O_HPF_ENABLE[0] == $past(ctrl_q[0][HPF_ENABLE_BIT])) &&
      (O_HPF_CUTOFF[0] == ($past(ctrl_q[0][HPF_ENABLE_BIT]) ?
       $past(ctrl_q[0][CUTOFF_MSB:CUTOFF_LSB]) : CUTOFF_OFF));
  endproperty
  a_hpf_gate: assert property (p_hpf_gate)
    else $error("cutoff applied without high-pass enable");

  property p_pin_select;
    (!$past(I_RESET) && !$past(I_RESET, 2) && ctrl_q[0][PIN_SEL_MSB:PIN_SEL_LSB] == 4'h4)
      |-> (sel_data[0] == $past(I_PIN[4], 2));
  endproperty
  a_pin_select: assert property (p_pin_select)
    else $error("data pin selection wrong");

  property p_two_channels;
    $past(bclk_rise[1] && src_ok[1]) && !$past(I_RESET)
      |-> O_MIC_VALID[2] && !O_MIC_VALID[3] && (O_MIC_DATA[2] == $past(sel_data[1]));
  endproperty
  a_two_channels: assert property (p_two_channels)
    else $error("rising edge sample not on even channel");

  property p_mode_gate;
    O_MIC_VALID[0] |-> $past(src_ok[0]) && $past(bclk_rise[0]);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("microphone sample from pin not in microphone mode");

  property p_clock_select;
    (!$past(I_RESET) && !$past(I_RESET, 2) && ctrl_q[0][CLK_SEL_MSB:CLK_SEL_LSB] == 3'h0)
      |-> (bclk_sel[0] == $past(I_BIT_CLOCK[0], 2));
  endproperty
  a_clock_select: assert property (p_clock_select)
    else $error("bit clock selection wrong");

  property p_rd_valid_follows;
    !$past(I_RESET) |-> (O_RD_VALID == $past(I_RD_EN));
  endproperty
  a_rd_valid_follows: assert property (p_rd_valid_follows)
    else $error("read valid does not follow read strobe");

  property p_rd_data_hold;
    (!$past(I_RD_EN) && !$past(I_RESET)) |-> $stable(O_RD_DATA);
  endproperty
  a_rd_data_hold: assert property (p_rd_data_hold)
    else $error("read data changed without a read");

  property p_unmapped_zero;
    (O_RD_VALID && !$past(rb_hit) && !$past(ctrl_hit[0]) && !$past(ctrl_hit[1]))
      |-> (O_RD_DATA == 16'h0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_ctrl0_read;
    (O_RD_VALID && $past(ctrl_hit[0])) |-> (O_RD_DATA == $past(ctrl_q[0]));
  endproperty
  a_ctrl0_read: assert property (p_ctrl0_read)
    else $error("first control register read wrong");

  property p_ctrl0_write;
    ($past(I_WR_EN && ctrl_hit[0]) && !$past(I_RESET)) |-> (ctrl_q[0] == $past(I_WR_DATA));
  endproperty
  a_ctrl0_write: assert property (p_ctrl0_write)
    else $error("first control register did not take write");

  property p_odd_channel;
    ($past(bclk_fall[0] && src_ok[0]) && !$past(I_RESET))
      |-> O_MIC_VALID[1] && !O_MIC_VALID[0] && (O_MIC_DATA[1] == $past(sel_data[0]));
  endproperty
  a_odd_channel: assert property (p_odd_channel)
    else $error("falling edge sample not on odd channel");

  property p_mode_gate_pair1;
    (!$past(src_ok[1]) && !$past(I_RESET)) |-> (O_MIC_VALID[3:2] == 2'b00);
  endproperty
  a_mode_gate_pair1: assert property (p_mode_gate_pair1)
    else $error("second pair sample from pin not in microphone mode");

  property p_mic_data_hold;
    (!$past(bclk_rise[0]) && !$past(I_RESET)) |-> $stable(O_MIC_DATA[0]);
  endproperty
  a_mic_data_hold: assert property (p_mic_data_hold)
    else $error("channel data changed without a bit clock edge");

  property p_hpf_gate_pair1;
    !$past(I_RESET) |-> (O_HPF_ENABLE[1] == $past(ctrl_q[1][HPF_ENABLE_BIT])) &&
      (O_HPF_CUTOFF[1] == ($past(ctrl_q[1][HPF_ENABLE_BIT]) ?
       $past(ctrl_q[1][CUTOFF_MSB:CUTOFF_LSB]) : CUTOFF_OFF));
  endproperty
  a_hpf_gate_pair1: assert property (p_hpf_gate_pair1)
    else $error("second pair cutoff applied without high-pass enable");

  c_readback_read: cover property (I_RD_EN && rb_hit ##1 O_RD_VALID && O_RD_DATA[0]);
  c_ctrl_write:    cover property (I_WR_EN && ctrl_hit[1]);
  c_mic_pair:      cover property (O_MIC_VALID[0] ##[1:20] O_MIC_VALID[1]);
  c_hpf_on:        cover property (O_HPF_ENABLE[1] && O_HPF_CUTOFF[1] == 3'h6);

endmodule

// [verif/mpd_mic_model.sv]
// two microphones sharing one data line, one per bit clock phase
`timescale 1ns/100ps
module mpd_mic_model (
  // bit clock from the device side
  input  wire logic i_bit_clock,
  // bits the two microphones present
  input  wire logic i_left_bit,
  input  wire logic i_right_bit,
  // shared data line
  output logic      o_data
);
  // ****************************************************************
  // line sharing
  // ****************************************************************
  logic phase_q;

  initial phase_q = 1'b0;

  // hand-over after a hold time, so the sampling edge still sees the old talker
  always @(i_bit_clock) begin
    #100;
    phase_q = i_bit_clock;
  end

  assign o_data = phase_q ? i_right_bit : i_left_bit;
endmodule

// [verif/test_mp_pin_readback_pdm_mic_config.sv]
// self-checking bench for pin readback and microphone pair control
`timescale 1ns/100ps
module test_mp_pin_readback_pdm_mic_config;
  import mpd_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic            clk;
  logic            rst;
  mpd_addr_t       addr;
  logic            wr_en;
  mpd_word_t       wr_data;
  logic            rd_en;
  mpd_word_t       rd_data;
  logic            rd_valid;
  mpd_pin_vec_t    mpe;
  mpd_mode_vec_t   mode;
  mpd_pin_vec_t    pin_q;
  mpd_pin_vec_t    pin_w;
  mpd_bclk_vec_t   bclk;
  mpd_mic_vec_t    mic_data;
  mpd_mic_vec_t    mic_valid;
  mpd_pair_vec_t   hpf_en;
  mpd_cutoff_vec_t hpf_cut;
  logic            pdm_line;
  logic            bit_clk;
  logic            left_bit;
  int              cs;
  int              mic_pin;
  int              errors;
  int              n_checks;
  int              n_valid [NUM_MICS];
  logic            exp_bit [NUM_MICS];

  mpd_top u_mpd_top (
    .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WR_EN(wr_en),
    .I_WR_DATA(wr_data), .I_RD_EN(rd_en), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
    .I_PIN_MULTIPURPOSE_ENABLE(mpe), .I_PIN_FUNCTION_MODE(mode), .I_PIN(pin_w),
    .I_BIT_CLOCK(bclk), .O_MIC_DATA(mic_data), .O_MIC_VALID(mic_valid),
    .O_HPF_ENABLE(hpf_en), .O_HPF_CUTOFF(hpf_cut)
  );

  mpd_mic_model u_mpd_mic_model (
    .i_bit_clock(bit_clk), .i_left_bit(left_bit), .i_right_bit(~left_bit), .o_data(pdm_line)
  );

  always_comb begin
    bclk = '0;
    bclk[cs] = bit_clk;
    pin_w = pin_q;
    if (mic_pin < NUM_PINS) begin
      pin_w[mic_pin] = pdm_line;
    end
  end

  // ****************************************************************
  // checking and access tasks
  // ****************************************************************
  task automatic chk(input mpd_word_t seen, input mpd_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input mpd_addr_t a, input mpd_word_t d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input mpd_addr_t a, input mpd_word_t exp);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk({15'h0, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask

  // route pin s to pair p on bit clock c, then run n bit clock periods
  task automatic mic_run(input int p, input int s, input int c, input mpd_mode_t m, input int n);
    bit ok;
    mode[s] = m;
    mic_pin = s;
    cs = c;
    left_bit = s[0];
    exp_bit[2*p] = left_bit;
    exp_bit[2*p+1] = ~left_bit;
    ok = (m == MODE_MIC_IN) && mpe[s];
    wr(MIC_CTRL0_ADDR + 16'(p), {4'h0, 4'(s), 1'b0, 3'(c), 4'h0});
    for (int k = 0; k < NUM_MICS; k++) n_valid[k] = 0;
    repeat (n) begin
      repeat (4) @(negedge clk);
      bit_clk = 1'b1;
      repeat (4) @(negedge clk);
      bit_clk = 1'b0;
    end
    repeat (8) @(negedge clk);
    for (int k = 0; k < NUM_MICS; k++) begin
      chk(16'(n_valid[k]), (k / 2 == p && ok) ? 16'(n) : 16'h0000);
    end
  endtask

  always @(negedge clk) begin
    for (int c = 0; c < NUM_MICS; c++) begin
      if (mic_valid[c] === 1'b1) begin
        n_valid[c]++;
        chk({15'h0, mic_data[c]}, {15'h0, exp_bit[c]});
      end
    end
  end

  // ****************************************************************
  // clock, watchdog and tests
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #500000;
    errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    addr = '0;
    wr_en = 1'b0;
    wr_data = '0;
    rd_en = 1'b0;
    mpe = '0;
    mode = '0;
    pin_q = '0;
    bit_clk = 1'b0;
    left_bit = 1'b0;
    cs = 0;
    mic_pin = NUM_PINS;
    errors = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < NUM_PINS; k++) rd(READBACK_BASE + 16'(k), READBACK_RESET);
    rd(MIC_CTRL0_ADDR, MIC_CTRL_RESET);
    rd(MIC_CTRL1_ADDR, MIC_CTRL_RESET);
    chk({8'h00, hpf_cut, hpf_en}, 16'h0000);
    rd(16'hF53E, 16'h0000);
    rd(16'hF562, 16'h0000);
    mpe = 14'h3FFF;
    for (int k = 0; k < NUM_PINS; k++) mode[k] = k[0] ? MODE_GP_IN_PORT : MODE_GP_IN;
    pin_q = 14'h2A5A;
    repeat (4) @(negedge clk);
    for (int k = 0; k < NUM_PINS; k++) rd(READBACK_BASE + 16'(k), {15'h0, pin_q[k]});
    wr(READBACK_BASE + 16'h0003, 16'hFFFF);
    rd(READBACK_BASE + 16'h0003, 16'h0001);
    mpe = 14'h0000;
    repeat (4) @(negedge clk);
    rd(READBACK_BASE + 16'h0001, 16'h0000);
    mpe = 14'h3FFF;
    pin_q = '0;
    repeat (4) @(negedge clk);
    pin_q[0] = 1'b1;
    rd(READBACK_BASE, 16'h0000);
    repeat (2) @(negedge clk);
    rd(READBACK_BASE, 16'h0001);
    for (int p = 0; p < NUM_PAIRS; p++) begin
      for (int c = 0; c < 7; c++) begin
        wr(MIC_CTRL0_ADDR + 16'(p), {1'b1, 3'(c), 4'h0, 1'b1, 3'h7, c[1], 3'h5});
        rd(MIC_CTRL0_ADDR + 16'(p), {1'b1, 3'(c), 4'h0, 1'b1, 3'h7, c[1], 3'h5});
        chk({13'h0, hpf_cut[p]}, c[1] ? 16'(c) : 16'h0000);
        chk({15'h0, hpf_en[p]}, {15'h0, c[1]});
      end
    end
    for (int s = 0; s < 5; s++) mic_run(s % 2, s, (s == 0) ? 0 : s + 2, MODE_MIC_IN, 3);
    mic_run(0, 2, 0, MODE_GP_IN, 2);
    mpe[3] = 1'b0;
    mic_run(1, 3, 1, MODE_MIC_IN, 2);
    finish_test();
  end
endmodule
